// ===== inc/smbtwd_pkg.sv
package smbtwd_pkg;

	// Field widths of the target write cycle.
	localparam int          BYTE_W          = 8;
	localparam int          ADDR_W          = 7;
	localparam int          CNT_W           = 4;

	// Receive target address after reset; the controller sends 88h / 89h.
	localparam logic [6:0]  DEF_TARGET_ADDR = 7'h44;
	localparam logic        RW_WRITE        = 1'b0;

	// Target register numbers carried in the command field.
	localparam logic [7:0]  REG_COMMAND     = 8'h00;
	localparam logic [7:0]  REG_MSG_ZERO    = 8'h04;
	localparam logic [7:0]  REG_MSG_ONE     = 8'h05;

	// Command types written to the command register.
	localparam logic [7:0]  CMD_WAKE_IRQ    = 8'h01;
	localparam logic [7:0]  CMD_POWER_DOWN  = 8'h02;
	localparam logic [7:0]  CMD_RESET_WARM  = 8'h03;
	localparam logic [7:0]  CMD_RESET_COLD  = 8'h04;
	localparam logic [7:0]  CMD_MSG_STOP    = 8'h05;
	localparam logic [7:0]  CMD_WATCHDOG    = 8'h06;

	// Bit counter values: last data bit and acknowledge bit.
	localparam logic [3:0]  CNT_LAST_DATA   = 4'h7;
	localparam logic [3:0]  CNT_ACK         = 4'h8;
	localparam logic [3:0]  CNT_RESET       = 4'h0;

	// Reset values.
	localparam logic [7:0]  MSG_RESET       = 8'h00;
	localparam logic        MSG_EN_RESET    = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD  = 3'b010,
		ST_DATA = 3'b011,
		ST_SKIP = 3'b100
	} smbtwd_state_t;

	// One-cycle system action requests.
	typedef struct packed {
		logic wake;
		logic mgmt_irq;
		logic power_down;
		logic reset_warm;
		logic reset_cold;
		logic watchdog;
	} smbtwd_action_t;

	// Power state as seen by the command decoder.
	typedef struct packed {
		logic asleep;
		logic me_powered;
		logic graceful_sleep;
	} smbtwd_power_t;

endpackage

// ===== rtl/smbtwd_decoder.sv
`timescale 1ns/1ps
module smbtwd_decoder (
	input  wire logic                      clock_i,      // System clock.
	input  wire logic                      rstn_i,       // Resume-well reset.
	input  wire logic                      scl_i,        // Link clock pin.
	input  wire logic                      sda_i,        // Link data pin in.
	output logic                           sda_o,        // Link data out.
	output logic                           sda_oe_o,     // Data pull low.
	input  wire logic [6:0]                receive_target_address_i, // Addr.
	input  wire smbtwd_pkg::smbtwd_power_t power_i,      // Power state.
	input  wire logic                      link_wake_status_clr_i, // Clear.
	input  wire logic                      power_button_override_status_clr_i,
	output smbtwd_pkg::smbtwd_action_t     actions_o,    // Action pulses.
	output logic                           link_wake_status_o,     // Sticky.
	output logic                           power_button_override_status_o,
	output logic                           msg_enable_o, // Messages allowed.
	output logic [7:0]                     message_byte_zero_o, // Message 0.
	output logic [7:0]                     message_byte_one_o   // Message 1.
);

	logic [7:0]                 link_shift_ff;
	logic [1:0]                 scl_sync_ff;
	logic [1:0]                 sda_sync_ff;
	logic                       scl_q_ff;
	logic                       sda_q_ff;
	logic                       scl_rise;
	logic                       scl_fall;
	logic                       start_evt;
	logic                       stop_evt;
	logic [3:0]                 bit_cnt_ff;
	logic [7:0]                 byte_ff;
	logic [7:0]                 cmd_reg_ff;
	smbtwd_pkg::smbtwd_state_t  state_ff;
	smbtwd_pkg::smbtwd_state_t  nxt_state;
	logic                       ack_ff;
	logic                       addr_match;
	logic                       ack_worthy;
	logic                       ack_clock;
	logic                       write_stb;
	logic                       cmd_write;
	logic                       cold_allowed;
	smbtwd_pkg::smbtwd_action_t actions_ff;
	smbtwd_pkg::smbtwd_action_t nxt_actions;
	logic                       link_wake_ff;
	logic                       pbo_status_ff;
	logic                       msg_en_ff;
	logic [7:0]                 msg_zero_ff;
	logic [7:0]                 msg_one_ff;

	// Link domain: data bits are caught on the link clock itself, so the
	// sample point is exact; the system side reads the byte only after the
	// eighth edge has been seen, while the register is known to be still.
	always_ff @(posedge scl_i) begin
		link_shift_ff <= {link_shift_ff[6:0], sda_i};
	end

	// Pin synchronisers for framing, start and stop detection.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_q_ff    <= 1'b1;
			sda_q_ff    <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
			scl_q_ff    <= scl_sync_ff[1];
			sda_q_ff    <= sda_sync_ff[1];
		end
	end

	assign scl_rise  = scl_sync_ff[1] & ~scl_q_ff;
	assign scl_fall  = ~scl_sync_ff[1] & scl_q_ff;
	assign start_evt = scl_sync_ff[1] & scl_q_ff & sda_q_ff & ~sda_sync_ff[1];
	assign stop_evt  = scl_sync_ff[1] & scl_q_ff & ~sda_q_ff & sda_sync_ff[1];
	assign ack_clock = scl_rise & (bit_cnt_ff == smbtwd_pkg::CNT_ACK);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			bit_cnt_ff <= smbtwd_pkg::CNT_RESET;
		end else if (start_evt || stop_evt) begin
			bit_cnt_ff <= smbtwd_pkg::CNT_RESET;
		end else if (scl_rise) begin
			if (bit_cnt_ff == smbtwd_pkg::CNT_ACK) begin
				bit_cnt_ff <= smbtwd_pkg::CNT_RESET;
			end else begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			byte_ff <= smbtwd_pkg::MSG_RESET;
		end else if (scl_rise && bit_cnt_ff == smbtwd_pkg::CNT_LAST_DATA) begin
			byte_ff <= link_shift_ff;
		end
	end

	assign addr_match = (byte_ff[7:1] == receive_target_address_i)
		&& (byte_ff[0] == smbtwd_pkg::RW_WRITE);

	always_comb begin
		nxt_state = state_ff;
		if (stop_evt) begin
			nxt_state = smbtwd_pkg::ST_IDLE;
		end else if (start_evt) begin
			nxt_state = smbtwd_pkg::ST_ADDR;
		end else if (ack_clock) begin
			unique case (state_ff)
				smbtwd_pkg::ST_IDLE: nxt_state = smbtwd_pkg::ST_IDLE;
				smbtwd_pkg::ST_ADDR: begin
					nxt_state = addr_match ? smbtwd_pkg::ST_CMD
						: smbtwd_pkg::ST_SKIP;
				end
				smbtwd_pkg::ST_CMD:  nxt_state = smbtwd_pkg::ST_DATA;
				smbtwd_pkg::ST_DATA: nxt_state = smbtwd_pkg::ST_SKIP;
				smbtwd_pkg::ST_SKIP: nxt_state = smbtwd_pkg::ST_SKIP;
				default:             nxt_state = smbtwd_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_ff <= smbtwd_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Bytes past the single data byte of a Byte Write are not acknowledged.
	assign ack_worthy = ((state_ff == smbtwd_pkg::ST_ADDR) && addr_match)
		|| (state_ff == smbtwd_pkg::ST_CMD)
		|| (state_ff == smbtwd_pkg::ST_DATA);

	// The pull-down starts after the falling edge that ends the eighth bit and
	// lets go after the falling edge that ends the acknowledge bit.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			ack_ff <= 1'b0;
		end else if (start_evt || stop_evt) begin
			ack_ff <= 1'b0;
		end else if (scl_fall) begin
			ack_ff <= (bit_cnt_ff == smbtwd_pkg::CNT_ACK) && ack_worthy;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = ack_ff;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cmd_reg_ff <= smbtwd_pkg::REG_COMMAND;
		end else if (ack_clock && state_ff == smbtwd_pkg::ST_CMD) begin
			cmd_reg_ff <= byte_ff;
		end
	end

	assign write_stb = ack_clock && (state_ff == smbtwd_pkg::ST_DATA);
	assign cmd_write = write_stb
		&& (cmd_reg_ff == smbtwd_pkg::REG_COMMAND);
	assign cold_allowed = !power_i.asleep || power_i.me_powered
		|| power_i.graceful_sleep;

	always_comb begin
		nxt_actions = '0;
		if (cmd_write) begin
			unique case (byte_ff)
				smbtwd_pkg::CMD_WAKE_IRQ: begin
					nxt_actions.wake     = power_i.asleep;
					nxt_actions.mgmt_irq = !power_i.asleep;
				end
				smbtwd_pkg::CMD_POWER_DOWN: nxt_actions.power_down = 1'b1;
				smbtwd_pkg::CMD_RESET_WARM: begin
					nxt_actions.reset_warm = !power_i.asleep;
				end
				smbtwd_pkg::CMD_RESET_COLD: begin
					nxt_actions.reset_cold = cold_allowed;
				end
				smbtwd_pkg::CMD_WATCHDOG: nxt_actions.watchdog = 1'b1;
				default: nxt_actions = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			actions_ff <= '0;
		end else begin
			actions_ff <= nxt_actions;
		end
	end

	assign actions_o = actions_ff;

	// Hardware setting beats a clear in the same cycle, so no event is lost.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			link_wake_ff <= 1'b0;
		end else if (cmd_write && byte_ff == smbtwd_pkg::CMD_WAKE_IRQ) begin
			link_wake_ff <= 1'b1;
		end else if (link_wake_status_clr_i) begin
			link_wake_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pbo_status_ff <= 1'b0;
		end else if (cmd_write && byte_ff == smbtwd_pkg::CMD_POWER_DOWN) begin
			pbo_status_ff <= 1'b1;
		end else if (power_button_override_status_clr_i) begin
			pbo_status_ff <= 1'b0;
		end
	end

	// Only the block reset brings messaging back; nothing else sets it.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			msg_en_ff <= smbtwd_pkg::MSG_EN_RESET;
		end else if (cmd_write && byte_ff == smbtwd_pkg::CMD_MSG_STOP) begin
			msg_en_ff <= 1'b0;
		end
	end

	// No guard against a host read in progress: the controller must wait.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			msg_zero_ff <= smbtwd_pkg::MSG_RESET;
			msg_one_ff  <= smbtwd_pkg::MSG_RESET;
		end else if (write_stb) begin
			if (cmd_reg_ff == smbtwd_pkg::REG_MSG_ZERO) begin
				msg_zero_ff <= byte_ff;
			end
			if (cmd_reg_ff == smbtwd_pkg::REG_MSG_ONE) begin
				msg_one_ff <= byte_ff;
			end
		end
	end

	assign link_wake_status_o             = link_wake_ff;
	assign power_button_override_status_o = pbo_status_ff;
	assign msg_enable_o                   = msg_en_ff;
	assign message_byte_zero_o            = msg_zero_ff;
	assign message_byte_one_o             = msg_one_ff;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	chk_ack_timing: assert property (
		$rose(sda_oe_o) |-> $past(scl_fall)
			&& $past(bit_cnt_ff) == smbtwd_pkg::CNT_ACK)
		else $error("Acknowledge began outside the ninth bit.");
	chk_addr_reject: assert property (
		ack_clock && state_ff == smbtwd_pkg::ST_ADDR && !addr_match
			&& !start_evt && !stop_evt
		|=> state_ff == smbtwd_pkg::ST_SKIP ##1 !sda_oe_o)
		else $error("Foreign address was not ignored.");
	chk_msg_store: assert property (
		write_stb && cmd_reg_ff == smbtwd_pkg::REG_MSG_ZERO
		|=> message_byte_zero_o == $past(byte_ff)
			&& message_byte_one_o == $past(message_byte_one_o))
		else $error("Message byte zero not stored.");
	chk_wake_irq: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_WAKE_IRQ
		|=> actions_o.wake == $past(power_i.asleep)
			&& actions_o.mgmt_irq == !$past(power_i.asleep)
			##1 actions_o == '0)
		else $error("Wake or interrupt choice wrong.");
	chk_wake_sticky: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_WAKE_IRQ
		|=> link_wake_status_o)
		else $error("Link wake status not set.");
	chk_pbo_down: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_POWER_DOWN
		|=> power_button_override_status_o && actions_o.power_down)
		else $error("Power-down command lost.");

	chk_warm_reset: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_RESET_WARM
		|=> actions_o.reset_warm == !$past(power_i.asleep)
			&& !actions_o.reset_cold)
		else $error("Warm reset gating wrong.");
	chk_cold_reset: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_RESET_COLD
		|=> actions_o.reset_cold == $past(cold_allowed))
		else $error("Cold reset gating wrong.");
	chk_msg_disable: assert property (
		!msg_enable_o |=> !msg_enable_o)
		else $error("Messaging came back without reset.");
	chk_watchdog_pulse: assert property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_WATCHDOG
		|=> actions_o.watchdog ##1 !actions_o.watchdog)
		else $error("Watchdog reload not a single pulse.");
	chk_action_cause: assert property (
		actions_o != '0 |-> $past(cmd_write))
		else $error("Action without a command register write.");

	chk_reserved_quiet: assert property (
		write_stb && cmd_reg_ff != smbtwd_pkg::REG_COMMAND
			&& cmd_reg_ff != smbtwd_pkg::REG_MSG_ZERO
			&& cmd_reg_ff != smbtwd_pkg::REG_MSG_ONE
		|=> actions_o == '0 && $stable(message_byte_zero_o)
			&& $stable(message_byte_one_o))
		else $error("Reserved register write had an effect.");

	cov_wake_asleep: cover property (
		cmd_write && byte_ff == smbtwd_pkg::CMD_WAKE_IRQ && power_i.asleep);
	cov_cold_reset: cover property (actions_o.reset_cold);
	cov_msg_one: cover property (
		write_stb && cmd_reg_ff == smbtwd_pkg::REG_MSG_ONE);
	cov_addr_skip: cover property (
		ack_clock && state_ff == smbtwd_pkg::ST_ADDR && !addr_match);

endmodule

// ===== verification/smbtwd_ctl_model.sv
`timescale 1ns/1ps
module smbtwd_ctl_model (
	input  wire logic sda_i,     // Resolved data line.
	output logic      scl_o,     // Link clock, idle high.
	output logic      sda_low_o  // High while pulling data low.
);
	logic lclk;

	initial begin
		lclk = 1'b0;
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Own 32 ns time base, offset so its rising edges never meet a rising edge of clock_i.
	initial begin
		#7;
		forever #16 lclk = ~lclk;
	end

	// A link phase of eight ticks keeps each level well above the four
	// system clocks the decoder needs to see it.
	task automatic phase();
		repeat (8) @(posedge lclk);
	endtask

	// Data changes two ticks after the clock falls, never with it.
	task automatic put_bit(input logic b, output logic seen);
		repeat (2) @(posedge lclk);
		sda_low_o <= ~b;
		phase();
		scl_o <= 1'b1;
		phase();
		seen = sda_i;
		scl_o <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask

	// Address, command and data in that order, each acked separately.
	task automatic frame(input logic [7:0] a, input logic [7:0] c,
			input logic [7:0] d, output logic [2:0] acks);
		sda_low_o <= 1'b0;
		phase();
		sda_low_o <= 1'b1;
		phase();
		scl_o <= 1'b0;
		send_byte(a, acks[2]);
		send_byte(c, acks[1]);
		send_byte(d, acks[0]);
		repeat (2) @(posedge lclk);
		sda_low_o <= 1'b1;
		phase();
		scl_o <= 1'b1;
		phase();
		sda_low_o <= 1'b0;
		phase();
	endtask
endmodule

// ===== verification/smbtwd_decoder_tb.sv
`timescale 1ns/1ps
module smbtwd_decoder_tb;
	logic                       clock_i;
	logic                       rstn_i;
	logic                       scl_w;
	logic                       ctl_low;
	logic                       sda_w;
	logic                       sda_o;
	logic                       sda_oe_o;
	logic [6:0]                 tgt_addr;
	smbtwd_pkg::smbtwd_power_t  power;
	logic                       lws_clr;
	logic                       pbo_clr;
	logic                       act_clr;
	smbtwd_pkg::smbtwd_action_t actions;
	logic [5:0]                 seen_act;
	logic                       lws;
	logic                       pbo;
	logic                       msg_en;
	logic [7:0]                 msg0;
	logic [7:0]                 msg1;
	logic [2:0]                 acks;
	logic [26:0]                tbl [13];
	int                         failures;
	int                         checked;

	// Open-drain data line with a pull-up.
	assign sda_w = (sda_oe_o ? sda_o : 1'b1) & ~ctl_low;

	smbtwd_decoder smbtwd_decoder_i (
		.clock_i                            (clock_i),
		.rstn_i                             (rstn_i),
		.scl_i                              (scl_w),
		.sda_i                              (sda_w),
		.sda_o                              (sda_o),
		.sda_oe_o                           (sda_oe_o),
		.receive_target_address_i           (tgt_addr),
		.power_i                            (power),
		.link_wake_status_clr_i             (lws_clr),
		.power_button_override_status_clr_i (pbo_clr),
		.actions_o                          (actions),
		.link_wake_status_o                 (lws),
		.power_button_override_status_o     (pbo),
		.msg_enable_o                       (msg_en),
		.message_byte_zero_o                (msg0),
		.message_byte_one_o                 (msg1)
	);

	smbtwd_ctl_model smbtwd_ctl_model_i (
		.sda_i     (sda_w),
		.scl_o     (scl_w),
		.sda_low_o (ctl_low)
	);

	initial clock_i = 1'b0;
	always #12.5 clock_i = ~clock_i;

	// Action pulses last one cycle, so they are gathered between frames.
	always @(negedge clock_i) begin
		if (act_clr) begin
			seen_act <= 6'h00;
		end else begin
			seen_act <= seen_act | actions;
		end
	end

	task automatic check(input string name, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic run(input logic [7:0] a, input logic [7:0] c,
			input logic [7:0] d);
		@(negedge clock_i);
		act_clr = 1'b1;
		lws_clr = 1'b1;
		pbo_clr = 1'b1;
		repeat (2) @(negedge clock_i);
		act_clr = 1'b0;
		lws_clr = 1'b0;
		pbo_clr = 1'b0;
		smbtwd_ctl_model_i.frame(a, c, d, acks);
		repeat (4) @(negedge clock_i);
	endtask

	task automatic do_reset();
		rstn_i = 1'b0;
		repeat (6) @(negedge clock_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clock_i);
	endtask

	initial begin
		repeat (40000) @(posedge clock_i);
		failures++;
		give_verdict();
	end

	initial begin
		// Fields: register, data, power, actions, wake and override status.
		tbl[0] = {8'h00, 8'h01, 3'h0, 6'h10, 2'h2};
		tbl[1] = {8'h00, 8'h01, 3'h4, 6'h20, 2'h2};
		tbl[2] = {8'h00, 8'h02, 3'h0, 6'h08, 2'h1};
		tbl[3] = {8'h00, 8'h03, 3'h0, 6'h04, 2'h0};
		tbl[4] = {8'h00, 8'h03, 3'h4, 6'h00, 2'h0};
		tbl[5] = {8'h00, 8'h04, 3'h0, 6'h02, 2'h0};
		tbl[6] = {8'h00, 8'h04, 3'h4, 6'h00, 2'h0};
		tbl[7] = {8'h00, 8'h04, 3'h6, 6'h02, 2'h0};
		tbl[8] = {8'h00, 8'h04, 3'h5, 6'h02, 2'h0};
		tbl[9] = {8'h00, 8'h06, 3'h0, 6'h01, 2'h0};
		tbl[10] = {8'h00, 8'h00, 3'h0, 6'h00, 2'h0};
		tbl[11] = {8'h00, 8'h07, 3'h0, 6'h00, 2'h0};
		tbl[12] = {8'h02, 8'h01, 3'h0, 6'h00, 2'h0};
		failures = 0;
		checked = 0;
		power = 3'h0;
		tgt_addr = smbtwd_pkg::DEF_TARGET_ADDR;
		lws_clr = 1'b0;
		pbo_clr = 1'b0;
		act_clr = 1'b0;
		do_reset();
		check("msg0 reset", msg0, 8'h00);
		check("msg enable reset", {7'h00, msg_en}, 8'h01);
		run(8'h88, smbtwd_pkg::REG_MSG_ZERO, 8'hA5);
		check("acks", {5'h00, acks}, 8'h07);
		check("msg0", msg0, 8'hA5);
		run(8'h88, smbtwd_pkg::REG_MSG_ONE, 8'h3C);
		check("msg1", msg1, 8'h3C);
		// The host has read msg0 above before it is replaced here.
		run(8'h88, smbtwd_pkg::REG_MSG_ZERO, 8'h5A);
		check("msg0 overwrite", msg0, 8'h5A);
		check("msg1 kept", msg1, 8'h3C);
		run(8'h8A, smbtwd_pkg::REG_MSG_ZERO, 8'h11);
		check("foreign acks", {5'h00, acks}, 8'h00);
		check("foreign msg0", msg0, 8'h5A);
		// The address is a live input, so a moved address must be honoured.
		tgt_addr = 7'h45;
		run(8'h8A, smbtwd_pkg::REG_MSG_ONE, 8'h69);
		check("moved address acks", {5'h00, acks}, 8'h07);
		check("moved address msg1", msg1, 8'h69);
		tgt_addr = smbtwd_pkg::DEF_TARGET_ADDR;
		run(8'h89, smbtwd_pkg::REG_MSG_ZERO, 8'h22);
		check("read bit acks", {5'h00, acks}, 8'h00);
		for (int i = 0; i < 13; i++) begin
			power = tbl[i][10:8];
			run(8'h88, tbl[i][26:19], tbl[i][18:11]);
			check("actions", {2'h0, seen_act}, {2'h0, tbl[i][7:2]});
			check("wake status", {7'h00, lws}, {7'h00, tbl[i][1]});
			check("override", {7'h00, pbo}, {7'h00, tbl[i][0]});
			check("cmd msg0", msg0, 8'h5A);
		end
		power = 3'h0;
		run(8'h88, smbtwd_pkg::REG_COMMAND, smbtwd_pkg::CMD_MSG_STOP);
		check("msg stop", {7'h00, msg_en}, 8'h00);
		run(8'h88, smbtwd_pkg::REG_MSG_ONE, 8'h00);
		check("msg stop held", {7'h00, msg_en}, 8'h00);
		do_reset();
		check("msg enable again", {7'h00, msg_en}, 8'h01);
		give_verdict();
	end
endmodule
